//--- logic/lsb_exec.sv
// Execute block for logic, shift, bit and relative branch operations
// Functional notes
// - Reg ops write accumulator when target select is 0, register when 1.
// - AND of accumulator and addressed register updates only the zero flag.
// - Add with carry sums accumulator, register and carry; updates carry, nibble, zero.
// - Arithmetic right shift keeps bit 7, bit 0 goes to carry; updates carry, zero.
// - Bit clear zeroes the selected bit of the register, flags untouched.
// - Bit set forces the selected bit to one, flags untouched.
// - Literal branch loads incremented PC plus signed 9-bit offset, flags untouched.
// - Literal branch takes two instruction cycles.
// - Accumulator branch adds unsigned accumulator to incremented PC, flags untouched.
// - Accumulator branch takes two instruction cycles.
`timescale 1ns/1ps
module lsb_exec
  import lsb_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Instruction issue
  input wire logic op_valid,
  input wire lsb_op_e op_code,
  input wire logic [6:0] reg_addr,
  input wire logic target_sel,
  input wire logic [2:0] bit_pos,
  input wire logic [8:0] rel_offset,
  output logic op_ready,
  output logic op_done,
  // Preload of register file and accumulator
  input wire logic ld_reg_we,
  input wire logic ld_acc_we,
  input wire logic [6:0] ld_addr,
  input wire logic [7:0] ld_data,
  // Register file observation
  input wire logic [6:0] obs_addr,
  output logic [7:0] obs_data,
  // Core state
  output logic [7:0] acc_out,
  output logic [14:0] pc_out,
  output logic overflow_out_flag,
  output logic nibble_overflow_flag,
  output logic result_null_flag
);

  // Whole state of the block
  typedef struct packed {
    lsb_st_e st;
    logic ready;
    logic done;
    logic [7:0] acc;
    logic c;
    logic dc;
    logic z;
    logic [14:0] pc;
    logic [7:0] obs;
    logic [LSB_REG_NUM-1:0][7:0] regs;
  } lsb_state_s;

  lsb_state_s st_r;
  lsb_state_s st_nxt;

  logic accept;
  logic [7:0] rd_val;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic [14:0] pc_inc;
  logic [14:0] bra_ofs;
  logic [14:0] brw_ofs;

  // An operation is taken only while the sequencer is not flushing
  assign accept = op_valid && st_r.ready;
  assign rd_val = st_r.regs[reg_addr];

  // Branch arithmetic works from the already-incremented PC
  assign pc_inc = st_r.pc + 15'h0001;
  assign bra_ofs = {{6{rel_offset[LSB_OFS_SIGN_POS]}}, rel_offset};
  assign brw_ofs = {7'h00, st_r.acc};

  // Result and flag unit
  lsb_alu u_alu (
    .op(op_code),
    .pos(bit_pos),
    .acc(st_r.acc),
    .rv(rd_val),
    .c_in(st_r.c),
    .dc_in(st_r.dc),
    .z_in(st_r.z),
    .res(alu_res),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .z_out(alu_z)
  );

  // Next-state logic: one instruction per cycle, branches add a flush cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'h0;
    st_nxt.obs = st_r.regs[obs_addr];
    case (st_r.st)
      LSB_ST_RUN: begin
        if (accept) begin
          if (lsb_is_branch(op_code)) begin
            // Second cycle is a discarded fetch
            st_nxt.st = LSB_ST_FLUSH;
            st_nxt.ready = 1'h0;
            if (op_code == LSB_OP_BRA) begin
              st_nxt.pc = pc_inc + bra_ofs;
            end else begin
              st_nxt.pc = pc_inc + brw_ofs;
            end
          end else begin
            st_nxt.pc = pc_inc;
            st_nxt.done = 1'h1;
            if (op_code != LSB_OP_NOP) begin
              st_nxt.c = alu_c;
              st_nxt.dc = alu_dc;
              st_nxt.z = alu_z;
            end
            // Destination choice for the two-operand forms
            if (lsb_is_reg_op(op_code) && !target_sel) begin
              st_nxt.acc = alu_res;
            end else if (op_code != LSB_OP_NOP) begin
              st_nxt.regs[reg_addr] = alu_res;
            end
          end
        end else begin
          // Preload only when no operation is offered, so it never races a write-back
          if (ld_reg_we) begin
            st_nxt.regs[ld_addr] = ld_data;
          end
          if (ld_acc_we) begin
            st_nxt.acc = ld_data;
          end
        end
      end
      LSB_ST_FLUSH: begin
        st_nxt.st = LSB_ST_RUN;
        st_nxt.ready = 1'h1;
        st_nxt.done = 1'h1;
      end
      default: begin
        st_nxt.st = LSB_ST_RUN;
        st_nxt.ready = 1'h1;
      end
    endcase
  end

  // State register; the register file clears with the rest of the core
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r.st <= LSB_ST_RUN;
      st_r.ready <= 1'h1;
      st_r.done <= 1'h0;
      st_r.acc <= LSB_ACC_RST;
      st_r.c <= LSB_FLAG_RST;
      st_r.dc <= LSB_FLAG_RST;
      st_r.z <= LSB_FLAG_RST;
      st_r.pc <= LSB_PC_RST;
      st_r.obs <= LSB_REG_RST;
      st_r.regs <= {LSB_REG_NUM{LSB_REG_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register
  assign op_ready = st_r.ready;
  assign op_done = st_r.done;
  assign obs_data = st_r.obs;
  assign acc_out = st_r.acc;
  assign pc_out = st_r.pc;
  assign overflow_out_flag = st_r.c;
  assign nibble_overflow_flag = st_r.dc;
  assign result_null_flag = st_r.z;

  // Reference sums for the flag checks
  logic [8:0] chk_sum;
  logic [4:0] chk_nib;
  assign chk_sum = {1'h0, st_r.acc} + {1'h0, rd_val} + {8'h00, st_r.c};
  assign chk_nib = {1'h0, st_r.acc[3:0]} + {1'h0, rd_val[3:0]} + {4'h0, st_r.c};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Destination is the accumulator for target select 0
  a_dest_acc: assert property (
    accept && lsb_is_reg_op(op_code) && !target_sel
    |=> st_r.acc == $past(alu_res) && st_r.regs[$past(reg_addr)] == $past(rd_val))
    else $error("accumulator destination not written");

  // Destination is the register for target select 1
  a_dest_reg: assert property (
    accept && lsb_is_reg_op(op_code) && target_sel
    |=> st_r.regs[$past(reg_addr)] == $past(alu_res) && $stable(st_r.acc))
    else $error("register destination not written");

  // AND touches only the zero flag
  a_and_zero: assert property (
    accept && op_code == LSB_OP_AND
    |=> $past(alu_res) == ($past(st_r.acc) & $past(rd_val))
        && st_r.z == ($past(alu_res) == 8'h00) && $stable({st_r.c, st_r.dc}))
    else $error("and result or flags wrong");

  // Add with carry result and carry out
  a_add_carry: assert property (
    accept && op_code == LSB_OP_ADDC
    |=> st_r.c == $past(chk_sum[8]) && $past(alu_res) == $past(chk_sum[7:0]))
    else $error("add with carry sum or carry wrong");

  // Nibble carry from bit 3 on addition
  a_add_nibble: assert property (
    accept && op_code == LSB_OP_ADDC |=> st_r.dc == $past(chk_nib[4]))
    else $error("nibble carry wrong");

  // Shift keeps the sign bit and moves bit 0 into carry
  a_shift_carry: assert property (
    accept && op_code == LSB_OP_ASR
    |=> st_r.c == $past(rd_val[0])
        && $past(alu_res) == {$past(rd_val[7]), $past(rd_val[7:1])}
        && $stable(st_r.dc))
    else $error("arithmetic shift wrong");

  // Bit clear leaves flags alone
  a_bit_clear: assert property (
    accept && op_code == LSB_OP_CLRB
    |=> !st_r.regs[$past(reg_addr)][$past(bit_pos)] && $stable({st_r.c, st_r.dc, st_r.z}))
    else $error("bit clear wrong");

  // Bit set leaves flags alone
  a_bit_set: assert property (
    accept && op_code == LSB_OP_SETB
    |=> st_r.regs[$past(reg_addr)][$past(bit_pos)] && $stable({st_r.c, st_r.dc, st_r.z}))
    else $error("bit set wrong");

  // Literal branch target and flags
  a_bra_target: assert property (
    accept && op_code == LSB_OP_BRA
    |=> st_r.pc == $past(pc_inc) + $past(bra_ofs) && $stable({st_r.c, st_r.dc, st_r.z}))
    else $error("literal branch target wrong");

  // Accumulator branch target and flags
  a_brw_target: assert property (
    accept && op_code == LSB_OP_BRW
    |=> st_r.pc == $past(pc_inc) + {7'h00, $past(st_r.acc)} && $stable({st_r.c, st_r.z}))
    else $error("accumulator branch target wrong");

  // Literal branch occupies two instruction cycles
  a_bra_cycles: assert property (
    accept && op_code == LSB_OP_BRA |=> !op_ready && !op_done ##1 op_ready && op_done)
    else $error("literal branch not two cycles");

  // Accumulator branch occupies two instruction cycles
  a_brw_cycles: assert property (
    accept && op_code == LSB_OP_BRW |=> !op_ready ##1 op_ready && op_done && $stable(st_r.pc))
    else $error("accumulator branch not two cycles");

  // Zero flag follows the result of the flag-setting forms
  a_zero_flag: assert property (
    accept && lsb_is_reg_op(op_code) |=> st_r.z == ($past(alu_res) == 8'h00))
    else $error("zero flag wrong");

  // Bit clear leaves the other seven bits and the accumulator alone
  a_clear_others: assert property (
    accept && op_code == LSB_OP_CLRB
    |=> st_r.regs[$past(reg_addr)] == ($past(rd_val) & ~(8'h01 << $past(bit_pos)))
        && $stable(st_r.acc))
    else $error("bit clear disturbed other bits");

  // Bit set leaves the other seven bits and the accumulator alone
  a_set_others: assert property (
    accept && op_code == LSB_OP_SETB
    |=> st_r.regs[$past(reg_addr)] == ($past(rd_val) | (8'h01 << $past(bit_pos)))
        && $stable(st_r.acc))
    else $error("bit set disturbed other bits");

  // Branches leave the accumulator and the register file alone
  a_branch_data: assert property (
    accept && lsb_is_branch(op_code)
    |=> $stable(st_r.acc) && $stable(st_r.regs))
    else $error("branch changed data state");

  // Second cycle of a branch is idle, so offers and preloads there are refused
  a_flush_idle: assert property (
    !op_ready
    |=> $stable(acc_out) && $stable(pc_out) && $stable(st_r.regs)
        && $stable({overflow_out_flag, nibble_overflow_flag, result_null_flag}))
    else $error("state changed in branch second cycle");

  // Accumulator branch keeps every flag, the nibble carry included
  a_brw_flags: assert property (
    accept && op_code == LSB_OP_BRW
    |=> $stable({st_r.c, st_r.dc, st_r.z}) && $stable(st_r.acc))
    else $error("accumulator branch changed flags");

  // Shift written back keeps bit 7 and drops bit 0
  a_shift_dest: assert property (
    accept && op_code == LSB_OP_ASR && target_sel
    |=> st_r.regs[$past(reg_addr)] == {$past(rd_val[7]), $past(rd_val[7:1])})
    else $error("shifted register value wrong");

  // Add with carry into the accumulator lands the unit's sum, equal to the reference sum
  a_add_dest: assert property (
    accept && op_code == LSB_OP_ADDC && !target_sel
    |=> acc_out == $past(chk_sum[7:0]))
    else $error("add with carry result not in accumulator");

  // AND written back lands the bitwise product of the operands
  a_and_dest: assert property (
    accept && op_code == LSB_OP_AND && target_sel
    |=> st_r.regs[$past(reg_addr)] == ($past(st_r.acc) & $past(rd_val)))
    else $error("and result not in register");

endmodule : lsb_exec

//--- logic/lsb_pkg.sv
// Package with operation codes, states, reset values and helpers for the execute block
package lsb_pkg;

  // Datapath widths
  localparam int LSB_DATA_W = 8;
  localparam int LSB_ADDR_W = 7;
  localparam int LSB_PC_W = 15;
  localparam int LSB_REG_NUM = 128;

  // Values after reset
  localparam logic [7:0] LSB_ACC_RST = 8'h00;
  localparam logic [14:0] LSB_PC_RST = 15'h0000;
  localparam logic [7:0] LSB_REG_RST = 8'h00;
  localparam logic LSB_FLAG_RST = 1'h0;

  // Field positions
  localparam int LSB_MSB_POS = 7;
  localparam int LSB_OFS_SIGN_POS = 8;

  // Instruction cycles taken by a relative branch
  localparam int LSB_BRANCH_CYCLES = 2;

  // Operation codes on the issue port
  typedef enum logic [2:0] {
    LSB_OP_AND = 3'b000,
    LSB_OP_ADDC = 3'b001,
    LSB_OP_ASR = 3'b010,
    LSB_OP_CLRB = 3'b011,
    LSB_OP_SETB = 3'b100,
    LSB_OP_BRA = 3'b101,
    LSB_OP_BRW = 3'b110,
    LSB_OP_NOP = 3'b111
  } lsb_op_e;

  // Sequencer states
  typedef enum logic {
    LSB_ST_RUN = 1'b0,
    LSB_ST_FLUSH = 1'b1
  } lsb_st_e;

  // Operations that pick their destination by the target select
  function automatic logic lsb_is_reg_op(input lsb_op_e op);
    lsb_is_reg_op = (op == LSB_OP_AND) || (op == LSB_OP_ADDC) || (op == LSB_OP_ASR);
  endfunction : lsb_is_reg_op

  // Operations that reload the program counter
  function automatic logic lsb_is_branch(input lsb_op_e op);
    lsb_is_branch = (op == LSB_OP_BRA) || (op == LSB_OP_BRW);
  endfunction : lsb_is_branch

endpackage : lsb_pkg

//--- logic/lsb_alu.sv
// Combinational result and flag unit for the register operations
`timescale 1ns/1ps
module lsb_alu
  import lsb_pkg::*;
(
  // Operation
  input wire lsb_op_e op,
  input wire logic [2:0] pos,
  // Operands
  input wire logic [7:0] acc,
  input wire logic [7:0] rv,
  // Flags in
  input wire logic c_in,
  input wire logic dc_in,
  input wire logic z_in,
  // Result and flags out
  output logic [7:0] res,
  output logic c_out,
  output logic dc_out,
  output logic z_out
);

  // One-hot mask for a bit position, shared by clear and set
  function automatic logic [7:0] bit_mask(input logic [2:0] p);
    bit_mask = 8'h01 << p;
  endfunction : bit_mask

  logic [8:0] sum;
  logic [4:0] nib;

  // Full and low-nibble sums carry the incoming carry flag
  assign sum = {1'h0, acc} + {1'h0, rv} + {8'h00, c_in};
  assign nib = {1'h0, acc[3:0]} + {1'h0, rv[3:0]} + {4'h0, c_in};

  // Flags pass through unless the operation updates them
  always_comb begin
    res = rv;
    c_out = c_in;
    dc_out = dc_in;
    z_out = z_in;
    case (op)
      LSB_OP_AND: begin
        res = acc & rv;
        z_out = (res == 8'h00);
      end
      LSB_OP_ADDC: begin
        res = sum[7:0];
        c_out = sum[8];
        dc_out = nib[4];
        z_out = (res == 8'h00);
      end
      LSB_OP_ASR: begin
        res = {rv[LSB_MSB_POS], rv[7:1]};
        c_out = rv[0];
        z_out = (res == 8'h00);
      end
      LSB_OP_CLRB: res = rv & ~bit_mask(pos);
      LSB_OP_SETB: res = rv | bit_mask(pos);
      default: res = rv;
    endcase
  end

endmodule : lsb_alu

//--- verification/tb_top.sv
// Self-checking testbench for the execute block, with a reference model of core state
`timescale 1ns/1ps
module tb_top
  import lsb_pkg::*;
;
  // Clock, reset and stimulus
  logic core_clk;
  logic rst;
  logic op_valid;
  lsb_op_e op_code;
  logic [6:0] reg_addr;
  logic target_sel;
  logic [2:0] bit_pos;
  logic [8:0] rel_offset;
  logic ld_reg_we;
  logic ld_acc_we;
  logic [6:0] ld_addr;
  logic [7:0] ld_data;
  logic [6:0] obs_addr;
  // Observed outputs
  logic op_ready;
  logic op_done;
  logic [7:0] obs_data;
  logic [7:0] acc_out;
  logic [14:0] pc_out;
  logic overflow_out_flag;
  logic nibble_overflow_flag;
  logic result_null_flag;
  // Reference model state and counters
  logic [7:0] m_acc;
  logic [7:0] m_reg [128];
  logic [14:0] m_pc;
  logic m_c;
  logic m_dc;
  logic m_z;
  int checks;
  int fail_count;

  lsb_exec u_dut (
    .core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .reg_addr(reg_addr), .target_sel(target_sel), .bit_pos(bit_pos),
    .rel_offset(rel_offset), .op_ready(op_ready), .op_done(op_done),
    .ld_reg_we(ld_reg_we), .ld_acc_we(ld_acc_we), .ld_addr(ld_addr), .ld_data(ld_data),
    .obs_addr(obs_addr), .obs_data(obs_data), .acc_out(acc_out), .pc_out(pc_out),
    .overflow_out_flag(overflow_out_flag), .nibble_overflow_flag(nibble_overflow_flag),
    .result_null_flag(result_null_flag)
  );

  // 100 MHz clock
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // Compare one value and count it
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // Preload accumulator and/or one register while no instruction is offered
  task automatic ld(input logic r_we, input logic a_we, input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    ld_reg_we <= r_we;
    ld_acc_we <= a_we;
    ld_addr <= a;
    ld_data <= d;
    @(posedge core_clk);
    ld_reg_we <= 1'h0;
    ld_acc_we <= 1'h0;
    if (r_we) m_reg[a] = d;
    if (a_we) m_acc = d;
  endtask : ld

  // Compare whole core state, one register through the observe port
  task automatic chk_state(input logic [6:0] a);
    chk("acc_out", 16'(m_acc), 16'(acc_out));
    chk("pc_out", 16'(m_pc), 16'(pc_out));
    chk("overflow_out_flag", 16'(m_c), 16'(overflow_out_flag));
    chk("nibble_overflow_flag", 16'(m_dc), 16'(nibble_overflow_flag));
    chk("result_null_flag", 16'(m_z), 16'(result_null_flag));
    @(posedge core_clk);
    obs_addr <= a;
    @(posedge core_clk);
    #1;
    chk("obs_data", 16'(m_reg[a]), 16'(obs_data));
  endtask : chk_state

  // Expected add with carry: nibble carry, carry and 8-bit sum
  function automatic logic [9:0] exp_addc(input logic [7:0] w, input logic [7:0] f,
                                          input logic c);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'h0, w} + {1'h0, f} + {8'h00, c};
    low = {1'h0, w[3:0]} + {1'h0, f[3:0]} + {4'h0, c};
    exp_addc = {low[4], full};
  endfunction : exp_addc

  // Issue one instruction, follow its handshake, update the model and compare
  task automatic run(input lsb_op_e op, input logic [6:0] a, input logic t,
                     input logic [2:0] b, input logic [8:0] k);
    logic [9:0] s;
    logic [7:0] r;
    logic br;
    br = (op == LSB_OP_BRA) || (op == LSB_OP_BRW);
    @(posedge core_clk);
    op_valid <= 1'h1;
    op_code <= op;
    reg_addr <= a;
    target_sel <= t;
    bit_pos <= b;
    rel_offset <= k;
    @(posedge core_clk);
    op_valid <= 1'h0;
    #1;
    // A branch holds off the next offer for its second cycle
    if (br) begin
      chk("op_ready", 16'h0000, 16'(op_ready));
      chk("op_done", 16'h0000, 16'(op_done));
      @(posedge core_clk);
      #1;
    end
    chk("op_done", 16'h0001, 16'(op_done));
    r = 8'h00;
    case (op)
      LSB_OP_AND: r = m_acc & m_reg[a];
      LSB_OP_ADDC: begin
        s = exp_addc(m_acc, m_reg[a], m_c);
        m_dc = s[9];
        m_c = s[8];
        r = s[7:0];
      end
      LSB_OP_ASR: begin
        r = {m_reg[a][7], m_reg[a][7:1]};
        m_c = m_reg[a][0];
      end
      LSB_OP_CLRB: m_reg[a][b] = 1'h0;
      LSB_OP_SETB: m_reg[a][b] = 1'h1;
      default: ;
    endcase
    // Register operations pick their destination and refresh the zero flag
    if (op inside {LSB_OP_AND, LSB_OP_ADDC, LSB_OP_ASR}) begin
      m_z = (r == 8'h00);
      if (t) m_reg[a] = r;
      else m_acc = r;
    end
    m_pc = m_pc + 15'h0001;
    if (op == LSB_OP_BRA) m_pc = m_pc + {{6{k[8]}}, k};
    if (op == LSB_OP_BRW) m_pc = m_pc + {7'h00, m_acc};
    chk_state(a);
  endtask : run

  // Watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    #200000;
    fail_count++;
    summarize();
  end

  // Main sequence
  initial begin
    logic [31:0] rnd;
    checks = 0;
    fail_count = 0;
    rst = 1'h1;
    op_valid = 1'h0;
    op_code = LSB_OP_NOP;
    reg_addr = 7'h00;
    target_sel = 1'h0;
    bit_pos = 3'h0;
    rel_offset = 9'h000;
    ld_reg_we = 1'h0;
    ld_acc_we = 1'h0;
    ld_addr = 7'h00;
    ld_data = 8'h00;
    obs_addr = 7'h00;
    m_acc = 8'h00;
    m_pc = 15'h0000;
    m_c = 1'h0;
    m_dc = 1'h0;
    m_z = 1'h0;
    foreach (m_reg[i]) m_reg[i] = 8'h00;
    void'($urandom(83));
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    #1;
    chk("op_ready", 16'h0001, 16'(op_ready));
    chk_state(7'h7f);
    // Corner cases: carries, zero results, sign keep, bit ends, branch extremes
    ld(1'h1, 1'h1, 7'h7f, 8'hff);
    run(LSB_OP_ADDC, 7'h7f, 1'h0, 3'h0, 9'h000);
    ld(1'h0, 1'h1, 7'h00, 8'h00);
    ld(1'h1, 1'h0, 7'h00, 8'hff);
    run(LSB_OP_ADDC, 7'h00, 1'h1, 3'h0, 9'h000);
    ld(1'h1, 1'h0, 7'h10, 8'h81);
    run(LSB_OP_ASR, 7'h10, 1'h1, 3'h0, 9'h000);
    run(LSB_OP_ASR, 7'h11, 1'h0, 3'h0, 9'h000);
    run(LSB_OP_AND, 7'h10, 1'h0, 3'h0, 9'h000);
    run(LSB_OP_SETB, 7'h7f, 1'h0, 3'h7, 9'h000);
    run(LSB_OP_CLRB, 7'h7f, 1'h1, 3'h0, 9'h000);
    run(LSB_OP_BRA, 7'h00, 1'h0, 3'h0, 9'h100);
    run(LSB_OP_BRA, 7'h00, 1'h0, 3'h0, 9'h0ff);
    ld(1'h0, 1'h1, 7'h00, 8'hff);
    run(LSB_OP_BRW, 7'h00, 1'h0, 3'h0, 9'h000);
    run(LSB_OP_NOP, 7'h00, 1'h0, 3'h0, 9'h000);
    // Offers and preloads at a branch take and in its second cycle are ignored
    @(posedge core_clk);
    op_valid <= 1'h1;
    op_code <= LSB_OP_BRA;
    rel_offset <= 9'h004;
    ld_acc_we <= 1'h1;
    ld_data <= 8'h5a;
    @(posedge core_clk);
    op_code <= LSB_OP_SETB;
    reg_addr <= 7'h20;
    bit_pos <= 3'h3;
    @(posedge core_clk);
    op_valid <= 1'h0;
    ld_acc_we <= 1'h0;
    #1;
    chk("op_done", 16'h0001, 16'(op_done));
    m_pc = m_pc + 15'h0005;
    chk_state(7'h20);
    // Random traffic over every operation code and target
    repeat (300) begin
      rnd = $urandom;
      if (rnd[31]) ld(1'h1, 1'h0, rnd[6:0], rnd[15:8]);
      if (rnd[30:29] == 2'h0) ld(1'h0, 1'h1, 7'h00, rnd[23:16]);
      run(lsb_op_e'(rnd[26:24]), rnd[6:0], rnd[27], rnd[10:8], rnd[20:12]);
    end
    summarize();
  end

endmodule : tb_top
